//--- qbs_pkg.sv
// quad-rate burst sram port: shared constants, states and state records
// assumes every design file except the synchroniser imports the whole package
package qbs_pkg;
  // data path shape
  localparam int DATA_W = 18;
  localparam int ADDR_W = 20;
  localparam int BURST = 4;
  localparam int ROW_W = DATA_W * BURST;
  localparam int LANE_W = 9;
  localparam int LANES = 8;
  localparam int IMP_W = 6;
  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int KSTOP_NS = 30;
  localparam int KSTOP_CYC = (KSTOP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_CYCLES = 2048;
  localparam int IMP_CYCLES = 1024;
  localparam logic [11:0] LOCK_LAST = 12'(LOCK_CYCLES - 1);
  localparam logic [9:0] IMP_LAST = 10'(IMP_CYCLES - 1);

  // read output phase
  typedef enum logic [1:0] {OUT_IDLE, OUT_FIRST, OUT_SECOND} qbs_out_e;

  // link state updated on positive clock rise
  typedef struct packed {
    logic rd_s1;
    logic rd_s2;
    logic [ADDR_W-1:0] raddr;
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] caddr;
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w2;
    logic [1:0] m0;
    logic [1:0] m2;
    qbs_out_e ophase;
    logic [ROW_W-1:0] burst;
    logic [DATA_W-1:0] q;
    logic oe_n;
    logic vld;
  } qbs_kpos_s;

  // link state updated on negative clock rise
  typedef struct packed {
    logic [DATA_W-1:0] w1;
    logic [DATA_W-1:0] w3;
    logic [1:0] m1;
    logic [1:0] m3;
    logic [DATA_W-1:0] q;
    logic oe_n;
    logic vld;
  } qbs_kneg_s;

  // core clock state
  typedef struct packed {
    logic k_prev;
    logic [7:0] idle;
    logic [11:0] lock_cnt;
    logic locked;
    logic [9:0] imp_cnt;
    logic [IMP_W-1:0] imp_code;
    logic echo_p;
    logic echo_n;
  } qbs_core_s;

  // reset values
  localparam qbs_kpos_s KPOS_RST = '{ophase: OUT_IDLE, oe_n: 1'h1, default: '0};
  localparam qbs_kneg_s KNEG_RST = '{oe_n: 1'h1, default: '0};
  localparam qbs_core_s CORE_RST = '0;
endpackage

//--- qbs_sync.sv
// two-flop synchroniser for levels entering a clock domain
// assumes the input is a slow level; a constant high makes a reset release
`timescale 1ns/1ps
`default_nettype none
module qbs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // first flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule
`default_nettype wire

//--- qbs_mem.sv
// burst row array: one write port with lane enables, one registered read
// assumes both ports run on the positive link clock
`timescale 1ns/1ps
`default_nettype none
module qbs_mem
  import qbs_pkg::*;
(
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [ROW_W-1:0] wdata,
  input wire logic [LANES-1:0] wlane,
  // read side
  input wire logic re,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [ROW_W-1:0] rdata_reg
);
  logic [ROW_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ROW_W-1:0] rdata_next;

  // read returns new lanes when a write hits the same row
  always_comb begin
    rdata_next = mem[raddr];
    for (int i = 0; i < LANES; i++) begin
      if (we && wlane[i] && (waddr == raddr)) begin
        rdata_next[i*LANE_W +: LANE_W] = wdata[i*LANE_W +: LANE_W];
      end
    end
    if (!re) begin
      rdata_next = rdata_reg;
    end
  end

  // lane-masked write and read register
  always_ff @(posedge clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (we && wlane[i]) begin
        mem[waddr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
      end
    end
    rdata_reg <= rdata_next;
  end
endmodule
`default_nettype wire

//--- qbs_port.sv
// quad-rate burst sram port: device-side control, data path and housekeeping
// assumes k_clk is the positive input clock and its complement the negative one;
// clk runs free at 125 MHz, nrst is asynchronous and active low
`timescale 1ns/1ps
`default_nettype none
module qbs_port
  import qbs_pkg::*;
#(
  parameter int STOP_CYCLES = KSTOP_CYC
) (
  // core clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link clock
  input wire logic k_clk,
  // port selects and shared address
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [ADDR_W-1:0] address,
  // write data and lane selects
  input wire logic [DATA_W-1:0] write_data,
  input wire logic [1:0] byte_write_select_n,
  // read data, its enable and valid flag
  output logic [DATA_W-1:0] read_data,
  output logic read_data_oe_n,
  output logic output_valid_flag,
  // echo clocks
  output logic echo_clock_out,
  output logic echo_clock_out_n,
  // delay loop and impedance
  input wire logic delay_loop_disable_n,
  input wire logic [IMP_W-1:0] impedance_reference_pin,
  output logic dll_locked,
  output logic [IMP_W-1:0] impedance_code
);
  // link-domain signals
  logic k_rst_n;
  logic dll_en_k;
  logic legacy;
  logic read_go;
  logic write_go;
  logic launch;
  logic fwd_hit;
  logic mem_re;
  logic mem_we;
  logic [ADDR_W-1:0] mem_raddr;
  logic [ROW_W-1:0] mem_rdata;
  logic [ROW_W-1:0] wrow;
  logic [LANES-1:0] wlane;
  logic [ROW_W-1:0] merged;
  qbs_kpos_s kp_reg;
  qbs_kpos_s kp_next;
  qbs_kneg_s kn_reg;
  qbs_kneg_s kn_next;
  // core-domain signals
  logic rst_n;
  logic k_s;
  logic dll_en_c;
  logic [IMP_W-1:0] imp_s;
  logic k_rise;
  logic k_edge;
  logic stopped;
  qbs_core_s c_reg;
  qbs_core_s c_next;

  // reset release in each domain
  qbs_sync #(.WIDTH(1)) u_rst_core (
    .clk(clk),
    .rst_n(nrst),
    .d(1'h1),
    .q(rst_n)
  );

  qbs_sync #(.WIDTH(1)) u_rst_link (
    .clk(k_clk),
    .rst_n(nrst),
    .d(1'h1),
    .q(k_rst_n)
  );

  // delay-loop strap into the link domain
  qbs_sync #(.WIDTH(1)) u_dll_link (
    .clk(k_clk),
    .rst_n(k_rst_n),
    .d(delay_loop_disable_n),
    .q(dll_en_k)
  );

  // link clock level, strap and impedance sense into the core domain
  qbs_sync #(.WIDTH(IMP_W + 2)) u_core_in (
    .clk(clk),
    .rst_n(rst_n),
    .d({k_clk, delay_loop_disable_n, impedance_reference_pin}),
    .q({k_s, dll_en_c, imp_s})
  );

  // row array
  qbs_mem u_mem (
    .clk(k_clk),
    .we(mem_we),
    .waddr(kp_reg.caddr),
    .wdata(wrow),
    .wlane(wlane),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata_reg(mem_rdata)
  );

  // request decode, array access and forwarding merge
  always_comb begin
    legacy = !dll_en_k;
    read_go = !read_port_select_n && !kp_reg.rd_s1;
    write_go = !write_port_select_n && !kp_reg.wr_s1 && !read_go;
    launch = legacy ? kp_reg.rd_s1 : kp_reg.rd_s2;
    mem_re = legacy ? read_go : kp_reg.rd_s1;
    mem_raddr = legacy ? address : kp_reg.raddr;
    mem_we = kp_reg.wr_s3;
    wrow = {kn_reg.w3, kp_reg.w2, kn_reg.w1, kp_reg.w0};
    wlane = {kn_reg.m3, kp_reg.m2, kn_reg.m1, kp_reg.m0};
    fwd_hit = kp_reg.wr_s3 && (kp_reg.caddr == kp_reg.raddr);
    merged = mem_rdata;
    for (int i = 0; i < LANES; i++) begin
      if (fwd_hit && wlane[i]) begin
        merged[i*LANE_W +: LANE_W] = wrow[i*LANE_W +: LANE_W];
      end
    end
  end

  // next state on the positive clock rise
  always_comb begin
    kp_next = kp_reg;
    kp_next.rd_s1 = read_go;
    kp_next.rd_s2 = kp_reg.rd_s1;
    kp_next.wr_s1 = write_go;
    kp_next.wr_s2 = kp_reg.wr_s1;
    kp_next.wr_s3 = kp_reg.wr_s2;
    if (read_go) begin
      kp_next.raddr = address;
    end
    if (write_go) begin
      kp_next.waddr = address;
    end
    // first and third write words with their lane selects
    if (kp_reg.wr_s1) begin
      kp_next.w0 = write_data;
      kp_next.m0 = ~byte_write_select_n;
    end
    if (kp_reg.wr_s2) begin
      kp_next.w2 = write_data;
      kp_next.m2 = ~byte_write_select_n;
      kp_next.caddr = kp_reg.waddr; // frees waddr for the next write
    end
    // read burst output sequence
    if (launch) begin
      kp_next.burst = merged;
      kp_next.q = merged[DATA_W-1:0];
      kp_next.ophase = OUT_FIRST;
    end else begin
      case (kp_reg.ophase)
        OUT_FIRST: begin
          kp_next.q = kp_reg.burst[3*DATA_W-1:2*DATA_W];
          kp_next.ophase = OUT_SECOND;
        end
        OUT_SECOND: begin
          kp_next.ophase = OUT_IDLE;
        end
        default: begin
          kp_next.ophase = OUT_IDLE;
        end
      endcase
    end
    kp_next.oe_n = (kp_next.ophase == OUT_IDLE);
    kp_next.vld = !kp_next.oe_n;
  end

  // positive-rise state register
  always_ff @(posedge k_clk or negedge k_rst_n) begin
    if (!k_rst_n) begin
      kp_reg <= KPOS_RST;
    end else begin
      kp_reg <= kp_next;
    end
  end

  // next state on the negative clock rise
  always_comb begin
    kn_next = kn_reg;
    if (kp_reg.wr_s2) begin
      kn_next.w1 = write_data;
      kn_next.m1 = ~byte_write_select_n;
    end
    if (kp_reg.wr_s3) begin
      kn_next.w3 = write_data;
      kn_next.m3 = ~byte_write_select_n;
    end
    case (kp_reg.ophase)
      OUT_FIRST: begin
        kn_next.q = kp_reg.burst[2*DATA_W-1:DATA_W];
      end
      OUT_SECOND: begin
        kn_next.q = kp_reg.burst[ROW_W-1:3*DATA_W];
      end
      default: begin
        kn_next.q = kn_reg.q;
      end
    endcase
    kn_next.oe_n = (kp_reg.ophase == OUT_IDLE);
    kn_next.vld = launch || (kp_reg.ophase == OUT_FIRST);
  end

  // negative-rise state register
  always_ff @(negedge k_clk or negedge k_rst_n) begin
    if (!k_rst_n) begin
      kn_reg <= KNEG_RST;
    end else begin
      kn_reg <= kn_next;
    end
  end

  // double-rate output: each half shows the word launched on its own rise
  assign read_data = k_clk ? kp_reg.q : kn_reg.q;
  assign read_data_oe_n = k_clk ? kp_reg.oe_n : kn_reg.oe_n;
  assign output_valid_flag = k_clk ? kp_reg.vld : kn_reg.vld;

  // clock watch, delay-loop lock, impedance refresh and echo clocks
  always_comb begin
    c_next = c_reg;
    k_rise = k_s && !c_reg.k_prev;
    k_edge = k_s != c_reg.k_prev;
    stopped = c_reg.idle >= 8'(STOP_CYCLES);
    c_next.k_prev = k_s;
    if (k_edge) begin
      c_next.idle = 8'h00;
    end else if (!stopped) begin
      c_next.idle = c_reg.idle + 8'h01;
    end
    if (!dll_en_c || stopped) begin
      c_next.lock_cnt = 12'h000;
      c_next.locked = 1'h0;
    end else if (k_rise && !c_reg.locked) begin
      c_next.lock_cnt = c_reg.lock_cnt + 12'h001;
      if (c_reg.lock_cnt == LOCK_LAST) begin
        c_next.locked = 1'h1;
      end
    end
    if (k_rise) begin
      c_next.imp_cnt = c_reg.imp_cnt + 10'h001;
      if (c_reg.imp_cnt == IMP_LAST) begin
        c_next.imp_code = imp_s;
      end
    end
    c_next.echo_p = k_s;
    c_next.echo_n = !k_s;
  end

  // core state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c_reg <= CORE_RST;
    end else begin
      c_reg <= c_next;
    end
  end

  // core outputs
  assign echo_clock_out = c_reg.echo_p;
  assign echo_clock_out_n = c_reg.echo_n;
  assign dll_locked = c_reg.locked;
  assign impedance_code = c_reg.imp_code;

  // link-side checks
  read_addr_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    read_go |=> kp_reg.raddr == $past(address))
    else $error("read address not latched");

  read_latency_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    read_go && !legacy |-> ##3 (kp_reg.ophase == OUT_FIRST && !kp_reg.oe_n))
    else $error("read burst not launched two rises after request");

  legacy_latency_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    read_go && legacy |-> ##2 (kp_reg.ophase == OUT_FIRST))
    else $error("legacy read not launched one rise after request");

  burst_order_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    kp_reg.ophase == OUT_FIRST |=>
      kp_reg.ophase == OUT_SECOND && kp_reg.q == $past(kp_reg.burst[3*DATA_W-1:2*DATA_W]))
    else $error("third burst word out of order");

  read_spacing_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    read_go ##1 !read_port_select_n |=> !kp_reg.rd_s1 && kp_reg.raddr == $past(kp_reg.raddr))
    else $error("second back-to-back read was not ignored");

  write_spacing_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    write_go ##1 !write_port_select_n |=> !kp_reg.wr_s1 && kp_reg.waddr == $past(kp_reg.waddr))
    else $error("second back-to-back write was not ignored");

  write_commit_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    write_go |-> ##3 (mem_we && kp_reg.caddr == $past(address, 3)))
    else $error("write not committed at its address");

  read_priority_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    !read_port_select_n && !write_port_select_n && !kp_reg.rd_s1 |-> read_go && !write_go)
    else $error("read lost arbitration");

  write_turn_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    !read_port_select_n && !write_port_select_n && kp_reg.rd_s1 |-> write_go && !read_go)
    else $error("write lost its turn after a read");

  tristate_a:
  assert property (@(posedge k_clk) disable iff (!k_rst_n)
    kp_reg.ophase == OUT_SECOND && !launch |=> kp_reg.oe_n && !kp_reg.vld)
    else $error("read outputs not released after burst");

  // core-side checks
  impedance_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    k_rise && c_reg.imp_cnt == IMP_LAST |=> c_reg.imp_code == $past(imp_s))
    else $error("impedance code not refreshed");

  lock_count_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    $rose(c_reg.locked) |-> $past(c_reg.lock_cnt) == LOCK_LAST)
    else $error("delay loop locked early");

  stop_reset_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    stopped |=> !c_reg.locked && c_reg.lock_cnt == 12'h000)
    else $error("stopped clock did not reset lock");

  // main scenarios
  back_to_back_c: cover property (@(posedge k_clk) disable iff (!k_rst_n)
    launch ##2 launch);
  forward_c: cover property (@(posedge k_clk) disable iff (!k_rst_n)
    launch && fwd_hit);
  alternate_c: cover property (@(posedge k_clk) disable iff (!k_rst_n)
    read_go ##1 write_go ##1 read_go);
  locked_c: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(c_reg.locked));
endmodule
`default_nettype wire

//--- qbs_ctrl_model.sv
// controller model: link clock, port selects, address, write words and lanes
// assumes the bench books requests by link edge index (odd edges are rises) ahead of time
`timescale 1ns/1ps
`default_nettype none
module qbs_ctrl_model
  import qbs_pkg::*;
(
  // link clock and requests
  output logic k_clk,
  output logic rsel_n,
  output logic wsel_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wd,
  output logic [1:0] bw_n,
  // read side as the device shows it
  input wire logic [DATA_W-1:0] rd,
  input wire logic oe_n,
  input wire logic vld
);
  int e = 0;
  int vld_bad = 0;
  logic vld_h = 1'b0;
  logic k_hold = 1'b0;
  logic r_at[int];
  logic w_at[int];
  logic [ADDR_W-1:0] a_at[int];
  logic [DATA_W+1:0] d_at[int];
  int got_e[$];
  logic [DATA_W-1:0] got_q[$];

  // 125 ns link clock; the bench may hold it low to stop it
  initial begin
    k_clk = 1'b0;
    #37;
    forever begin
      #62.5;
      if (!k_hold) begin
        k_clk = ~k_clk;
      end
    end
  end

  // book a read or a write for the rise at link edge at
  task automatic put_rd(int at, logic [ADDR_W-1:0] a);
    r_at[at] = 1'b1;
    a_at[at] = a;
  endtask

  task automatic put_wr(int at, logic [ADDR_W-1:0] a, logic [ROW_W-1:0] row,
                        logic [7:0] m);
    w_at[at] = 1'b1;
    a_at[at] = a;
    for (int i = 0; i < BURST; i++) begin
      d_at[at + 2 + i] = {m[2*i+:2], row[DATA_W*i+:DATA_W]};
    end
  endtask

  // a quarter period after each edge: set up the next edge, sample the device
  initial begin
    rsel_n = 1'b1;
    wsel_n = 1'b1;
    addr = '0;
    {bw_n, wd} = '0;
    #1;
    forever begin
      @(k_clk);
      e = e + 1;
      #31.25;
      rsel_n = !r_at.exists(e + 1);
      wsel_n = !w_at.exists(e + 1);
      addr = a_at.exists(e + 1) ? a_at[e + 1] : ~addr;
      {bw_n, wd} = d_at.exists(e + 1) ? d_at[e + 1] : ~{bw_n, wd};  // junk outside bursts
      if (vld_h !== !oe_n) vld_bad++;
      vld_h = vld;
      if (oe_n === 1'b0) begin
        got_e.push_back(e);
        got_q.push_back(rd);
      end
    end
  end
endmodule
`default_nettype wire

//--- qbs_port_tb.sv
// bench for the burst sram port: reset, lock, bursts, lanes, forwarding, arbitration
// assumes the controller model drives the link side on its own quarter-period timing
`timescale 1ns/1ps
`default_nettype none
module qbs_port_tb
  import qbs_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic dl_n = 1'b1;
  logic [IMP_W-1:0] zq = 6'h2a;
  logic k_clk, rsel_n, wsel_n, oe_n, vld, echo, echo_n, locked;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wd, rd;
  logic [1:0] bw_n;
  logic [IMP_W-1:0] zcode;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [ROW_W-1:0] mem[logic [ADDR_W-1:0]];
  int exp_e[$];
  logic [DATA_W-1:0] exp_q[$];

  // device under test, stop count widened for the slow bench link clock
  qbs_port #(.STOP_CYCLES(16)) dut_u (.clk(clk), .nrst(nrst), .k_clk(k_clk),
    .read_port_select_n(rsel_n), .write_port_select_n(wsel_n), .address(addr),
    .write_data(wd), .byte_write_select_n(bw_n), .read_data(rd), .read_data_oe_n(oe_n),
    .output_valid_flag(vld), .echo_clock_out(echo), .echo_clock_out_n(echo_n),
    .delay_loop_disable_n(dl_n), .impedance_reference_pin(zq), .dll_locked(locked),
    .impedance_code(zcode));

  // memory controller on the far side
  qbs_ctrl_model ctl_u (.k_clk(k_clk), .rsel_n(rsel_n), .wsel_n(wsel_n), .addr(addr),
    .wd(wd), .bw_n(bw_n), .rd(rd), .oe_n(oe_n), .vld(vld));

  // core clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 45000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic check(string what, logic [71:0] seen, logic [71:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [ROW_W-1:0] row_of(logic [8:0] s);
    for (int i = 0; i < BURST; i++) row_of[DATA_W*i+:DATA_W] = {s, 9'(i)};
  endfunction

  function automatic int nr();
    return (ctl_u.e + 4) | 1;
  endfunction

  // book a write and fold its enabled lanes into the shadow rows
  task automatic wr(int at, logic [ADDR_W-1:0] a, logic [ROW_W-1:0] row, logic [7:0] m);
    ctl_u.put_wr(at, a, row, m);
    for (int k = 0; k < LANES; k++) begin
      if (!m[k]) mem[a][LANE_W*k+:LANE_W] = row[LANE_W*k+:LANE_W];
    end
  endtask

  // book a read and the four words it must return, with their link edges
  task automatic rd_exp(int at, logic [ADDR_W-1:0] a, int lat);
    ctl_u.put_rd(at, a);
    for (int i = 0; i < BURST; i++) begin
      exp_e.push_back(at + 2 * lat + i);
      exp_q.push_back(mem[a][DATA_W*i+:DATA_W]);
    end
  endtask

  // wait past the last booked word, then match every word seen
  task automatic drain();
    while (ctl_u.e < exp_e[$] + 4) @(posedge k_clk);
    check("rd_words", 72'(ctl_u.got_q.size()), 72'(exp_q.size()));
    while (exp_q.size() > 0 && ctl_u.got_q.size() > 0) begin
      check("rd_edge", 72'(ctl_u.got_e.pop_front()), 72'(exp_e.pop_front()));
      check("rd_data", 72'(ctl_u.got_q.pop_front()), 72'(exp_q.pop_front()));
    end
    exp_e.delete();
    exp_q.delete();
    ctl_u.got_e.delete();
    ctl_u.got_q.delete();
  endtask

  task automatic t_reset();
    repeat (2) @(posedge k_clk);
    #20;
    check("rst_out", 72'({oe_n, vld, locked, zcode}), 72'({3'b100, 6'h00}));
  endtask

  // lock count, impedance refresh and echo clocks
  task automatic t_lock();
    repeat (1000) @(posedge k_clk);
    check("imp_early", 72'(zcode), 72'(6'h00));
    repeat (40) @(posedge k_clk);
    check("imp_first", 72'(zcode), 72'(6'h2a));
    @(negedge clk) zq = 6'h15;
    repeat (1000) @(posedge k_clk);
    check("lock_early", 72'(locked), 72'(1'b0));
    check("imp_hold", 72'(zcode), 72'(6'h2a));
    repeat (20) @(posedge k_clk);
    check("lock_done", 72'(locked), 72'(1'b1));
    check("imp_next", 72'(zcode), 72'(6'h15));
    @(posedge k_clk);
    #50;
    check("echo_hi", 72'({echo, echo_n}), 72'(2'b10));
    @(negedge k_clk);
    #50;
    check("echo_lo", 72'({echo, echo_n}), 72'(2'b01));
  endtask

  // a link clock held still drops the lock
  task automatic t_stop();
    check("stop_pre", 72'(locked), 72'(1'b1));
    @(negedge k_clk);
    ctl_u.k_hold = 1'b1;
    #300;
    check("stop_lock", 72'(locked), 72'(1'b0));
    ctl_u.k_hold = 1'b0;
    repeat (4) @(posedge k_clk);
  endtask

  // back-to-back writes and reads, refused repeats, masked lanes
  task automatic t_bursts();
    int b;
    b = nr();
    ctl_u.put_wr(b + 6, 20'h0_0002, row_of(9'h0ee), 8'h00);  // refused repeat
    wr(b, 20'h0_0002, row_of(9'h011), 8'h00);
    wr(b + 4, 20'h0_0000, row_of(9'h022), 8'h00);
    wr(b + 8, 20'h0_0001, row_of(9'h033), 8'h00);
    wr(b + 12, 20'h0_0000, row_of(9'h044), 8'h96);
    rd_exp(b + 20, 20'h0_0000, 2);
    ctl_u.put_rd(b + 22, 20'h0_0001);  // refused repeat
    rd_exp(b + 24, 20'h0_0002, 2);
    rd_exp(b + 28, 20'h0_0001, 2);
    drain();
  endtask

  // forwarding and both selects low: read, write, read
  task automatic t_concur();
    int b;
    b = nr();
    ctl_u.put_wr(b + 12, 20'h0_0004, row_of(9'h0dd), 8'h00);  // loses
    ctl_u.put_wr(b + 16, 20'h0_0004, row_of(9'h0cc), 8'h00);  // loses
    wr(b, 20'h0_0004, row_of(9'h055), 8'h00);
    wr(b + 4, 20'h0_0003, row_of(9'h066), 8'h00);
    rd_exp(b + 6, 20'h0_0003, 2);
    rd_exp(b + 12, 20'h0_0004, 2);
    ctl_u.put_rd(b + 14, 20'h0_0004);  // loses
    wr(b + 14, 20'h0_0004, row_of(9'h077), 8'h00);
    rd_exp(b + 16, 20'h0_0004, 2);
    rd_exp(b + 20, 20'h0_0004, 2);
    drain();
    check("vld_lead", 72'(ctl_u.vld_bad), 72'(0));
  endtask

  // delay loop off: one-cycle read latency
  task automatic t_legacy();
    @(negedge clk) dl_n = 1'b0;
    repeat (8) @(posedge k_clk);
    rd_exp(nr(), 20'h0_0001, 1);
    drain();
  endtask

  // main sequence
  initial begin
    t_reset();
    repeat (2) @(posedge k_clk);
    @(negedge clk) nrst = 1'b1;
    t_lock();
    t_bursts();
    t_concur();
    t_stop();
    t_legacy();
    tally_and_finish();
  end
endmodule
`default_nettype wire
